// ---- design/fifo_pkg.sv ----
// Purpose: shared constants for the flag-timed word buffer
// Assumes: one clock, APB register access, 32-bit data
// Notes: offsets are byte addresses on the APB bus
package fifo_pkg;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 4;
  localparam int SYNC_STAGES = 2;
  localparam int THR_W = 4;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] COUNT_OFF = 8'h08;

  // Control fields and reset value
  localparam int CTRL_LOOK_BIT = 0;
  localparam int CTRL_AE_LSB = 8;
  localparam int CTRL_AF_LSB = 16;
  localparam logic [THR_W-1:0] AE_THR_RST = 4'h1;
  localparam logic [THR_W-1:0] AF_THR_RST = 4'h1;

  // Status fields
  localparam int ST_EMPTY = 0;
  localparam int ST_NEMPTY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_NFULL = 3;
  localparam int ST_UNDER = 4;
  localparam int ST_OVER = 5;
  localparam int ST_LOOK = 6;

  // Count fields
  localparam int CNT_POP_LSB = 0;
  localparam int CNT_PUSH_LSB = 16;

  // Output stage of the lookahead path
  typedef enum logic {
    OUT_IDLE = 1'b0,
    OUT_HELD = 1'b1
  } out_state_t;
endpackage

// ---- design/word_ring.sv ----
// Purpose: word storage with pointers passed through synchronisers
// Assumes: in_valid held by the writer until taken
// Notes: fill levels seen by each side lag the far pointer
`timescale 1ns/10ps
`default_nettype none
module word_ring #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8,
  parameter int PTR_W = 4,
  parameter int STAGES = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic [PTR_W-1:0] wr_ptr,
  output logic [PTR_W-1:0] rd_ptr,
  output logic [PTR_W-1:0] wr_fill,
  output logic [PTR_W-1:0] rd_fill
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PTR_W-1:0] wsync_q [STAGES];
  logic [PTR_W-1:0] rsync_q [STAGES];
  logic full_q, full_d;
  logic ready_q, ready_d;
  logic push, pop;

  ////////////////////////////////////////////////////////////////
  // Pointer and full flag next values
  always_comb begin
    push = in_valid & ~full_q;
    pop = out_ready & out_valid;
    wr_d = wr_q + PTR_W'(push);
    rd_d = rd_q + PTR_W'(pop);
    // Full only sees the read pointer after the synchroniser
    full_d = (wr_d - rsync_q[STAGES-1]) == PTR_W'(DEPTH);
    // Ready kept as its own flop so the pin needs no inverter
    ready_d = ~full_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
      full_q <= 1'b0;
      ready_q <= 1'b1;
      for (int i = 0; i < STAGES; i++) begin
        wsync_q[i] <= '0;
        rsync_q[i] <= '0;
      end
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      full_q <= full_d;
      ready_q <= ready_d;
      // First stage feeds only the next stage
      wsync_q[0] <= wr_q;
      rsync_q[0] <= rd_q;
      for (int i = 1; i < STAGES; i++) begin
        wsync_q[i] <= wsync_q[i-1];
        rsync_q[i] <= rsync_q[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Storage, written at the write pointer slot
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q[PTR_W-2:0]] <= in_data;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Side views
  assign in_ready = ready_q;
  assign full = full_q;
  assign wr_ptr = wr_q;
  assign rd_ptr = rd_q;
  assign wr_fill = wr_q - rsync_q[STAGES-1];
  assign rd_fill = wsync_q[STAGES-1] - rd_q;
  assign out_valid = rd_fill != '0;
  assign out_data = mem_q[rd_q[PTR_W-2:0]];

  property p_sync_lag;
    @(posedge pclk) disable iff (!presetn)
    ##2 wsync_q[STAGES-1] == $past(wr_q, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag)
    else $error("write pointer view not two cycles late");
endmodule
`default_nettype wire

// ---- design/flag_timed_fifo.sv ----
// Purpose: word buffer with flag timing, lookahead output and APB
// Assumes: push and pop sides share pclk; APB master holds each request until pready
// Notes: change the read mode only while the buffer is empty
`timescale 1ns/10ps
`default_nettype none
module flag_timed_fifo
  import fifo_pkg::*;
#(
  parameter int DEPTH = fifo_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fifo_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic push_request,
  input wire logic [fifo_pkg::DATA_W-1:0] write_data_in,
  input wire logic [fifo_pkg::PAR_W-1:0] write_parity_in,
  output logic push_ready,
  input wire logic pop_request,
  output logic [fifo_pkg::DATA_W-1:0] read_data_out,
  output logic [fifo_pkg::PAR_W-1:0] read_parity_out,
  output logic empty_flag,
  output logic full_flag,
  output logic nearly_empty_flag,
  output logic nearly_full_flag,
  output logic underflow_error,
  output logic overflow_error,
  output logic [fifo_pkg::PTR_W-1:0] pop_pointer_count,
  output logic [fifo_pkg::PTR_W-1:0] push_pointer_count
);
  import fifo_pkg::*;

  localparam int WORD_W = DATA_W + PAR_W;

  ////////////////////////////////////////////////////////////////
  // Declarations
  logic look_q, look_d;
  logic [THR_W-1:0] ae_thr_q, ae_thr_d;
  logic [THR_W-1:0] af_thr_q, af_thr_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] status_w, count_w, ctrl_w;
  logic wr_access;

  out_state_t state_q, state_d;
  logic [WORD_W-1:0] word_q, word_d;
  logic avail_q, avail_d;
  logic empty_q, empty_d;
  logic under_q, under_d;
  logic over_q, over_d;
  logic nempty_q, nempty_d;
  logic nfull_q, nfull_d;
  logic [PTR_W-1:0] popcnt_q, popcnt_d;
  logic [PTR_W-1:0] pushcnt_q, pushcnt_d;

  logic ring_pop, ring_valid, ring_ready, ring_full;
  logic [WORD_W-1:0] ring_data;
  logic [PTR_W-1:0] ring_wr, ring_rd, ring_wfill, ring_rfill;
  logic [PTR_W-1:0] left_after;
  logic load;

  ////////////////////////////////////////////////////////////////
  // Storage with synchronised pointer views
  word_ring #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH),
    .PTR_W(PTR_W),
    .STAGES(SYNC_STAGES)
  ) ring (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(push_request),
    .in_ready(ring_ready),
    .in_data({write_parity_in, write_data_in}),
    .out_valid(ring_valid),
    .out_ready(ring_pop),
    .out_data(ring_data),
    .full(ring_full),
    .wr_ptr(ring_wr),
    .rd_ptr(ring_rd),
    .wr_fill(ring_wfill),
    .rd_fill(ring_rfill)
  );

  ////////////////////////////////////////////////////////////////
  // Read side: output stage, empty and underflow
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    load = 1'b0;
    if (look_q) begin
      // Prefetch one stage after the word is seen, hence one edge later
      load = avail_q & ((state_q == OUT_IDLE) | pop_request);
      if (load) begin
        state_d = OUT_HELD;
      end else if (pop_request) begin
        state_d = OUT_IDLE;
      end
      ring_pop = load;
    end else begin
      ring_pop = pop_request & avail_q;
      state_d = OUT_IDLE;
    end
    if (ring_pop) begin
      word_d = ring_data;
    end
    left_after = ring_rfill - PTR_W'(ring_pop);
    avail_d = ring_valid & (left_after != '0);
    if (look_q) begin
      empty_d = state_d != OUT_HELD;
    end else begin
      empty_d = ~avail_d;
    end
    under_d = pop_request & empty_q;
    nempty_d = left_after <= PTR_W'(ae_thr_q);
    popcnt_d = ring_rd;
  end

  // All read-side state moves on the pop clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= OUT_IDLE;
      word_q <= '0;
      avail_q <= 1'b0;
      empty_q <= 1'b1;
      under_q <= 1'b0;
      nempty_q <= 1'b1;
      popcnt_q <= '0;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      avail_q <= avail_d;
      empty_q <= empty_d;
      under_q <= under_d;
      nempty_q <= nempty_d;
      popcnt_q <= popcnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Write side: overflow, nearly-full and push count
  always_comb begin
    over_d = push_request & ring_full;
    nfull_d = ring_wfill >= (PTR_W'(DEPTH) - PTR_W'(af_thr_q));
    pushcnt_d = ring_wr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_q <= 1'b0;
      nfull_q <= 1'b0;
      pushcnt_q <= '0;
    end else begin
      over_q <= over_d;
      nfull_q <= nfull_d;
      pushcnt_q <= pushcnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // APB slave: zero-wait answer in the first access cycle
  always_comb begin
    ctrl_w = '0;
    ctrl_w[CTRL_LOOK_BIT] = look_q;
    ctrl_w[CTRL_AE_LSB +: THR_W] = ae_thr_q;
    ctrl_w[CTRL_AF_LSB +: THR_W] = af_thr_q;
    status_w = '0;
    status_w[ST_EMPTY] = empty_q;
    status_w[ST_NEMPTY] = nempty_q;
    status_w[ST_FULL] = ring_full;
    status_w[ST_NFULL] = nfull_q;
    status_w[ST_UNDER] = under_q;
    status_w[ST_OVER] = over_q;
    status_w[ST_LOOK] = look_q;
    count_w = '0;
    count_w[CNT_POP_LSB +: PTR_W] = popcnt_q;
    count_w[CNT_PUSH_LSB +: PTR_W] = pushcnt_q;
    // Data is latched in setup so prdata stays a flop output
    pready_d = psel & ~penable;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (psel & ~penable) begin
      unique case (paddr)
        CTRL_OFF: prdata_d = ctrl_w;
        STATUS_OFF: prdata_d = status_w;
        COUNT_OFF: prdata_d = count_w;
        default: begin
          prdata_d = '0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    wr_access = psel & penable & pready_q & pwrite & ~pslverr_q;
    look_d = look_q;
    ae_thr_d = ae_thr_q;
    af_thr_d = af_thr_q;
    if (wr_access && paddr == CTRL_OFF) begin
      look_d = pwdata[CTRL_LOOK_BIT];
      ae_thr_d = pwdata[CTRL_AE_LSB +: THR_W];
      af_thr_d = pwdata[CTRL_AF_LSB +: THR_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      look_q <= 1'b0;
      ae_thr_q <= AE_THR_RST;
      af_thr_q <= AF_THR_RST;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      look_q <= look_d;
      ae_thr_q <= ae_thr_d;
      af_thr_q <= af_thr_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs, each a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign push_ready = ring_ready;
  assign full_flag = ring_full;
  assign read_data_out = word_q[DATA_W-1:0];
  assign read_parity_out = word_q[WORD_W-1:DATA_W];
  assign empty_flag = empty_q;
  assign nearly_empty_flag = nempty_q;
  assign nearly_full_flag = nfull_q;
  assign underflow_error = under_q;
  assign overflow_error = over_q;
  assign pop_pointer_count = popcnt_q;
  assign push_pointer_count = pushcnt_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Clock phase is fixed, so the late case never arises
  sequence s_first_push_std;
    push_request && ring_ready && ring_wr == ring_rd && empty_q
      && !look_q && state_q == OUT_IDLE;
  endsequence
  sequence s_first_push_look;
    push_request && ring_ready && ring_wr == ring_rd && empty_q
      && look_q && state_q == OUT_IDLE;
  endsequence

  property p_empty_std;
    s_first_push_std ##1 !look_q [*3] |-> empty_q ##1 !empty_q;
  endproperty
  a_empty_std: assert property (p_empty_std)
    else $error("empty did not drop on third edge");

  property p_empty_look;
    s_first_push_look ##1 look_q [*4] |-> empty_q ##1 !empty_q;
  endproperty
  a_empty_look: assert property (p_empty_look)
    else $error("lookahead empty did not drop on fourth edge");

  property p_look_show;
    look_q && $fell(empty_q) |-> word_q == $past(ring_data);
  endproperty
  a_look_show: assert property (p_look_show)
    else $error("lookahead word not shown as empty cleared");

  property p_std_hold;
    !look_q && !(pop_request && !empty_q) |=> $stable(word_q);
  endproperty
  a_std_hold: assert property (p_std_hold)
    else $error("standard read data moved without pop");

  property p_underflow;
    pop_request && empty_q |=> underflow_error;
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow not raised on pop while empty");

  // Underflow is a per-edge report, not a sticky flag
  property p_under_clear;
    !pop_request |=> !underflow_error;
  endproperty
  a_under_clear: assert property (p_under_clear)
    else $error("underflow stayed up with no pop");

  property p_overflow;
    push_request && full_flag |=> overflow_error && $stable(ring_wr);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("write to full buffer not refused");

  // Overflow drops as soon as the writer stops asking
  property p_over_clear;
    !push_request |=> !overflow_error;
  endproperty
  a_over_clear: assert property (p_over_clear)
    else $error("overflow stayed up with no push");

  property p_pop_count;
    ##1 pop_pointer_count == $past(ring_rd);
  endproperty
  a_pop_count: assert property (p_pop_count)
    else $error("pop count does not follow read pointer");

  property p_push_count;
    $changed(push_pointer_count) |-> $past(push_request, 2);
  endproperty
  a_push_count: assert property (p_push_count)
    else $error("push count moved without a push");

  property p_parity;
    ring_pop |=> {read_parity_out, read_data_out} == $past(ring_data);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity moved apart from its word");
endmodule
`default_nettype wire

// ---- bench/user_side.sv ----
// Purpose: user logic on the push and pop sides of the buffer
// Assumes: shares pclk with the buffer; every task drive is an NBA after an edge
// Notes: released data lines show the inverse of the last word
`timescale 1ns/10ps
`default_nettype none
module user_side
  import fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic push_ready,
  input wire logic empty_flag,
  output logic push_request,
  output logic [fifo_pkg::DATA_W-1:0] write_data_in,
  output logic [fifo_pkg::PAR_W-1:0] write_parity_in,
  output logic pop_request
);
  // Quiet at time zero
  initial begin
    push_request = 1'b0;
    write_data_in = '0;
    write_parity_in = '0;
    pop_request = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Push one word, held stable until the buffer takes it
  task automatic push_word(input logic [DATA_W-1:0] d, input logic [PAR_W-1:0] p);
    @(posedge pclk);
    push_request <= 1'b1;
    write_data_in <= d;
    write_parity_in <= p;
    do @(posedge pclk); while (!push_ready);
    push_request <= 1'b0;
    // Inverted so a stale word never looks valid
    write_data_in <= ~d;
    write_parity_in <= ~p;
  endtask

  // Request regardless of full, for the refusal case
  task automatic hold_push(input int n);
    @(posedge pclk);
    push_request <= 1'b1;
    repeat (n) @(posedge pclk);
    push_request <= 1'b0;
  endtask

  // Pop one word, waiting while nothing is there
  task automatic pop_word();
    @(posedge pclk);
    pop_request <= 1'b1;
    do @(posedge pclk); while (empty_flag);
    pop_request <= 1'b0;
  endtask

  // Pop regardless of empty, for the underflow case
  task automatic hold_pop(input int n);
    @(posedge pclk);
    pop_request <= 1'b1;
    repeat (n) @(posedge pclk);
    pop_request <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/flag_timed_fifo_test.sv ----
// Purpose: self-checking bench for the flag-timed buffer
// Assumes: push, pop and APB sides share pclk at 10 MHz
// Notes: popped words are checked by the monitor in standard mode only
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module flag_timed_fifo_test;
  import fifo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, look;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] write_data_in, read_data_out, d;
  logic [PAR_W-1:0] write_parity_in, read_parity_out;
  logic push_request, push_ready, pop_request, empty_flag, full_flag;
  logic nearly_empty_flag, nearly_full_flag, underflow_error, overflow_error;
  logic [PTR_W-1:0] pop_pointer_count, push_pointer_count;
  logic [DATA_W+PAR_W-1:0] notes[$];
  logic [DATA_W+PAR_W-1:0] exp_w;
  int n_errors, compares, cyc;
  integer seed = 32'h928ce451;

  flag_timed_fifo #(.DEPTH(FIFO_DEPTH)) u_flag_timed_fifo (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .push_request(push_request), .write_data_in(write_data_in),
    .write_parity_in(write_parity_in), .push_ready(push_ready), .pop_request(pop_request),
    .read_data_out(read_data_out), .read_parity_out(read_parity_out),
    .empty_flag(empty_flag), .full_flag(full_flag), .nearly_empty_flag(nearly_empty_flag),
    .nearly_full_flag(nearly_full_flag), .underflow_error(underflow_error),
    .overflow_error(overflow_error), .pop_pointer_count(pop_pointer_count),
    .push_pointer_count(push_pointer_count));

  user_side u_user_side (
    .pclk(pclk), .push_ready(push_ready), .empty_flag(empty_flag),
    .push_request(push_request), .write_data_in(write_data_in),
    .write_parity_in(write_parity_in), .pop_request(pop_request));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; 3000 cycles is over twenty times the sequence
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; waits on pready, takes data at that edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Flags, errors, counts and word at their reset state
  task automatic check_idle();
    `CHK("empty pair", 2'b11, {empty_flag, nearly_empty_flag})
    `CHK("full pair", 2'b00, {full_flag, nearly_full_flag})
    `CHK("errors", 2'b00, {underflow_error, overflow_error})
    `CHK("counts", 8'h00, {pop_pointer_count, push_pointer_count})
    `CHK("word", 36'h0, {read_data_out, read_parity_out})
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: a standard-mode pop shows the oldest noted word
  always @(posedge pclk) begin
    if (presetn && pop_request && !empty_flag && !look) begin
      #1;
      exp_w = (notes.size() > 0) ? notes.pop_front() : 'x;
      `CHK("pop word", exp_w, {read_data_out, read_parity_out})
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    look = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check_idle();
    apb(1'b0, CTRL_OFF, 32'h0);
    `CHK("ctrl reset", 32'h00010100, rd)
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK("status reset", 32'h00000003, rd)
    apb(1'b1, 8'h0c, 32'hffffffff);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    // First word, standard mode: empty clears on the third edge
    d = $random(seed);
    u_user_side.push_word(d, 4'h5);
    notes.push_back({d, 4'h5});
    repeat (2) begin
      @(posedge pclk);
      #1;
      `CHK("empty early", 1'b1, empty_flag)
    end
    @(posedge pclk);
    #1;
    `CHK("empty third", 1'b0, empty_flag)
    `CHK("no pop no word", 36'h0, {read_data_out, read_parity_out})
    `CHK("push count", 4'h1, push_pointer_count)
    u_user_side.pop_word();
    // Fill until refused, then overrun
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      d = $random(seed);
      u_user_side.push_word(d, d[3:0]);
      notes.push_back({d, d[3:0]});
    end
    repeat (2) @(posedge pclk);
    #1;
    `CHK("full", 3'b110, {full_flag, nearly_full_flag, push_ready})
    u_user_side.hold_push(2);
    #1;
    `CHK("overflow", 1'b1, overflow_error)
    // Drain with random stalls; dropped word must not come out
    repeat (FIFO_DEPTH) begin
      repeat ($random(seed) & 3) @(posedge pclk);
      u_user_side.pop_word();
    end
    repeat (4) @(posedge pclk);
    #1;
    `CHK("drained flags", 2'b11, {empty_flag, nearly_empty_flag})
    `CHK("drained counts", 8'h99, {pop_pointer_count, push_pointer_count})
    u_user_side.hold_pop(1);
    #1;
    `CHK("underflow", 1'b1, underflow_error)
    // Lookahead: word shows with empty on the fourth edge, no pop
    apb(1'b1, CTRL_OFF, 32'h00010101);
    look = 1'b1;
    d = $random(seed);
    u_user_side.push_word(d, 4'ha);
    repeat (3) @(posedge pclk);
    #1;
    `CHK("look early", 1'b1, empty_flag)
    @(posedge pclk);
    #1;
    `CHK("look fourth", 1'b0, empty_flag)
    `CHK("look word", {d, 4'ha}, {read_data_out, read_parity_out})
    apb(1'b0, STATUS_OFF, 32'h0);
    `CHK("status look", 32'h00000042, rd)
    // Reset in mid-run with a word stored
    u_user_side.push_word(d, 4'h3);
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    look = 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    check_idle();
    print_verdict();
  end
endmodule
`default_nettype wire
